//--- design/ssc_top.sv
// serial port status and control flags with an AXI4-Lite register file
// assumes the shift engines drive the event inputs as one-cycle pulses on i_clk_sys
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps

module ssc_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // axi4-lite write response
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic o_rvalid,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rready,
    // shift engine events
    input wire logic i_shift_busy,
    input wire logic i_rx_done,
    input wire logic [7:0] i_rx_data,
    input wire logic i_tx_done,
    input wire logic i_byte_is_data,
    input wire logic i_start_det,
    input wire logic i_stop_det,
    input wire logic i_addr_match,
    input wire logic i_rw_bit,
    input wire logic i_ack_det,
    input wire logic i_ua_req,
    // engine configuration
    output logic o_pins_to_port,
    output logic o_i2c_sel,
    output logic o_spi_master,
    output logic [6:0] o_spi_divider,
    output logic o_clk_idle_high,
    output logic o_i2c_clk_release,
    output logic [3:0] o_port_mode,
    output logic [7:0] o_slave_addr,
    output logic o_tx_load,
    output logic [7:0] o_tx_data,
    // interrupt
    output logic o_irq
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (ADDR_W < 8)
    begin : g_addr_chk
        $error("ssc_top: ADDR_W must be at least 8");
    end
    // ****************************************
    // mode decoding
    // ****************************************
    function automatic logic ssc_is_i2c(input logic [3:0] m);
        ssc_is_i2c = (m == ssc_pkg::MODE_I2C_S7) || (m == ssc_pkg::MODE_I2C_S10)
            || (m == ssc_pkg::MODE_I2C_FWM) || (m == ssc_pkg::MODE_I2C_S7_SP)
            || (m == ssc_pkg::MODE_I2C_S10_SP);
    endfunction : ssc_is_i2c
    function automatic logic ssc_is_spi_master(input logic [3:0] m);
        ssc_is_spi_master = (m == ssc_pkg::MODE_SPI_M4) || (m == ssc_pkg::MODE_SPI_M16)
            || (m == ssc_pkg::MODE_SPI_M64) || (m == ssc_pkg::MODE_SPI_MTMR);
    endfunction : ssc_is_spi_master
    function automatic logic ssc_is_ten_bit(input logic [3:0] m);
        ssc_is_ten_bit = (m == ssc_pkg::MODE_I2C_S10) || (m == ssc_pkg::MODE_I2C_S10_SP);
    endfunction : ssc_is_ten_bit
    function automatic logic ssc_sp_irq(input logic [3:0] m);
        ssc_sp_irq = (m == ssc_pkg::MODE_I2C_S7_SP) || (m == ssc_pkg::MODE_I2C_S10_SP);
    endfunction : ssc_sp_irq
    function automatic logic [6:0] ssc_divider(input logic [3:0] m);
        unique case (m)
            ssc_pkg::MODE_SPI_M4: ssc_divider = ssc_pkg::DIV_4;
            ssc_pkg::MODE_SPI_M16: ssc_divider = ssc_pkg::DIV_16;
            ssc_pkg::MODE_SPI_M64: ssc_divider = ssc_pkg::DIV_64;
            default: ssc_divider = ssc_pkg::DIV_NONE;
        endcase
    endfunction : ssc_divider
    // ****************************************
    // state
    // ****************************************
    ssc_pkg::ssc_state_t st_reg;
    ssc_pkg::ssc_state_t st_next;
    logic do_write;
    logic do_read;
    logic i2c_on;
    logic [7:0] wb;
    logic [7:0] rd_addr;
    logic buf_write;
    logic buf_read;
    logic [ssc_pkg::IRQ_W-1:0] ev;
    always_comb
    begin
        st_next = st_reg;
        wb = st_reg.w_byte;
        rd_addr = i_araddr[7:0];
        ev = '0;
        i2c_on = st_reg.i2c_sel;
        do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
        do_read = i_arvalid && st_reg.arready;
        buf_write = do_write && st_reg.w_lane0 && (st_reg.aw_addr == ssc_pkg::OFS_DATA_BUF);
        buf_read = do_read && (rd_addr == ssc_pkg::OFS_DATA_BUF);
        // write channel capture, either order
        if (i_awvalid && st_reg.awready)
        begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = i_awaddr[7:0];
        end
        if (i_wvalid && st_reg.wready)
        begin
            st_next.w_held = 1'b1;
            st_next.w_byte = i_wdata[7:0];
            st_next.w_lane0 = i_wstrb[0];
        end
        if (st_reg.bvalid && i_bready)
        begin
            st_next.bvalid = 1'b0;
        end
        // register writes
        st_next.tx_load = 1'b0;
        if (do_write)
        begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = ssc_pkg::RESP_OKAY;
            unique case (st_reg.aw_addr)
                ssc_pkg::OFS_CONTROL:
                begin
                    if (st_reg.w_lane0)
                    begin
                        // flags only clear from software, a set event below still wins
                        st_next.write_collision_flag = st_reg.write_collision_flag
                            && wb[ssc_pkg::CTL_WRITE_COLLISION_FLAG];
                        st_next.receive_overflow_flag = st_reg.receive_overflow_flag
                            && wb[ssc_pkg::CTL_OVFL];
                        st_next.port_enable_bit = wb[ssc_pkg::CTL_EN];
                        st_next.clock_polarity_bit = wb[ssc_pkg::CTL_CKP];
                        st_next.port_mode_field = wb[3:0];
                    end
                end
                ssc_pkg::OFS_STATUS, ssc_pkg::OFS_DATA_BUF:
                begin
                    st_next.sts = st_reg.sts;
                end
                ssc_pkg::OFS_SLV_ADDR:
                begin
                    if (st_reg.w_lane0)
                    begin
                        st_next.slave_address_register = wb;
                        st_next.sts.address_update_flag = 1'b0;
                    end
                end
                ssc_pkg::OFS_IRQ_STS:
                begin
                    if (st_reg.w_lane0)
                    begin
                        st_next.irq_sts = st_reg.irq_sts & ~wb[ssc_pkg::IRQ_W-1:0];
                    end
                end
                ssc_pkg::OFS_IRQ_MASK:
                begin
                    if (st_reg.w_lane0)
                    begin
                        st_next.irq_mask = wb[ssc_pkg::IRQ_W-1:0];
                    end
                end
                default:
                begin
                    st_next.bresp = ssc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // data buffer write: load or collide
        if (buf_write)
        begin
            if (i_shift_busy || st_reg.tx_in_flight)
            begin
                // the word is dropped so the running shift stays intact
                st_next.write_collision_flag = 1'b1;
                ev[ssc_pkg::IRQ_WRITE_COLLISION_FLAG] = 1'b1;
            end
            else if (st_reg.port_enable_bit)
            begin
                st_next.tx_load = 1'b1;
                st_next.tx_data = wb;
                st_next.serial_data_buffer = wb;
                st_next.tx_in_flight = 1'b1;
                if (i2c_on)
                begin
                    st_next.sts.buffer_full_flag = 1'b1;
                end
            end
        end
        // read channel
        if (st_reg.rvalid && i_rready)
        begin
            st_next.rvalid = 1'b0;
        end
        if (do_read)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp = ssc_pkg::RESP_OKAY;
            st_next.rdata = '0;
            unique case (rd_addr)
                ssc_pkg::OFS_CONTROL:
                    st_next.rdata[7:0] = {st_reg.write_collision_flag,
                        st_reg.receive_overflow_flag, st_reg.port_enable_bit,
                        st_reg.clock_polarity_bit, st_reg.port_mode_field};
                ssc_pkg::OFS_STATUS:
                    st_next.rdata[7:0] = {2'h0, st_reg.sts};
                ssc_pkg::OFS_DATA_BUF:
                    st_next.rdata[7:0] = st_reg.serial_data_buffer;
                ssc_pkg::OFS_SLV_ADDR:
                    st_next.rdata[7:0] = st_reg.slave_address_register;
                ssc_pkg::OFS_IRQ_STS:
                    st_next.rdata[ssc_pkg::IRQ_W-1:0] = st_reg.irq_sts;
                ssc_pkg::OFS_IRQ_MASK:
                    st_next.rdata[ssc_pkg::IRQ_W-1:0] = st_reg.irq_mask;
                default:
                    st_next.rresp = ssc_pkg::RESP_SLVERR;
            endcase
            if (buf_read && !st_reg.tx_in_flight)
            begin
                st_next.sts.buffer_full_flag = 1'b0;
            end
        end
        // engine events
        if (i_tx_done && st_reg.port_enable_bit)
        begin
            st_next.tx_in_flight = 1'b0;
            ev[ssc_pkg::IRQ_BYTE] = 1'b1;
            if (i2c_on && !i_rx_done)
            begin
                st_next.sts.buffer_full_flag = 1'b0;
            end
        end
        if (i_rx_done && st_reg.port_enable_bit)
        begin
            ev[ssc_pkg::IRQ_BYTE] = 1'b1;
            // a spi master starts every byte itself, so it cannot overrun
            if (st_reg.sts.buffer_full_flag && !buf_read
                && !ssc_is_spi_master(st_reg.port_mode_field))
            begin
                st_next.receive_overflow_flag = 1'b1;
                ev[ssc_pkg::IRQ_OVFL] = 1'b1;
            end
            else
            begin
                st_next.serial_data_buffer = i_rx_data;
                st_next.sts.buffer_full_flag = 1'b1;
            end
            if (i2c_on)
            begin
                st_next.sts.data_not_addr = i_byte_is_data;
            end
        end
        if (i2c_on)
        begin
            if (i_start_det || i_stop_det || i_ack_det)
            begin
                st_next.sts.read_dir = 1'b0;
            end
            if (i_addr_match)
            begin
                st_next.sts.read_dir = i_rw_bit;
            end
            if (i_start_det)
            begin
                st_next.sts.start_seen = 1'b1;
                st_next.sts.stop_seen = 1'b0;
                ev[ssc_pkg::IRQ_START] = ssc_sp_irq(st_reg.port_mode_field);
            end
            if (i_stop_det)
            begin
                st_next.sts.stop_seen = 1'b1;
                st_next.sts.start_seen = 1'b0;
                ev[ssc_pkg::IRQ_STOP] = ssc_sp_irq(st_reg.port_mode_field);
            end
            if (i_ua_req && ssc_is_ten_bit(st_reg.port_mode_field))
            begin
                st_next.sts.address_update_flag = 1'b1;
            end
        end
        if (!st_next.port_enable_bit)
        begin
            st_next.sts.start_seen = 1'b0;
            st_next.sts.stop_seen = 1'b0;
            st_next.tx_in_flight = 1'b0;
        end
        // decoded here so the engine selects leave straight from flops
        st_next.i2c_sel = st_next.port_enable_bit && ssc_is_i2c(st_next.port_mode_field);
        st_next.spi_master = st_next.port_enable_bit && ssc_is_spi_master(st_next.port_mode_field);
        st_next.spi_divider = ssc_divider(st_next.port_mode_field);
        // interrupt, set wins over clear
        st_next.irq_sts = st_next.irq_sts | ev;
        st_next.irq = |(st_next.irq_sts & st_next.irq_mask);
        st_next.awready = !st_next.aw_held && !st_next.bvalid;
        st_next.wready = !st_next.w_held && !st_next.bvalid;
        st_next.arready = !st_next.rvalid;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs, all from the state register
    // ****************************************
    assign o_awready = st_reg.awready;
    assign o_wready = st_reg.wready;
    assign o_bvalid = st_reg.bvalid;
    assign o_bresp = st_reg.bresp;
    assign o_arready = st_reg.arready;
    assign o_rvalid = st_reg.rvalid;
    assign o_rdata = st_reg.rdata;
    assign o_rresp = st_reg.rresp;
    assign o_pins_to_port = st_reg.port_enable_bit;
    assign o_i2c_sel = st_reg.i2c_sel;
    assign o_spi_master = st_reg.spi_master;
    assign o_spi_divider = st_reg.spi_divider;
    assign o_clk_idle_high = st_reg.clock_polarity_bit;
    assign o_i2c_clk_release = st_reg.clock_polarity_bit;
    assign o_port_mode = st_reg.port_mode_field;
    assign o_slave_addr = st_reg.slave_address_register;
    assign o_tx_load = st_reg.tx_load;
    assign o_tx_data = st_reg.tx_data;
    assign o_irq = st_reg.irq;

endmodule : ssc_top

//--- design/ssc_pkg.sv
// constants, field layouts and state types of the serial port status/control block
// assumes an AXI4-Lite master with 32-bit data drives the register file
package ssc_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_DATA_BUF = 8'h00;
    localparam logic [7:0] OFS_SLV_ADDR = 8'h04;
    localparam logic [7:0] OFS_IRQ_STS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_CONTROL = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h94;

    // ****************************************
    // control field positions
    // ****************************************
    localparam int CTL_WRITE_COLLISION_FLAG = 7;
    localparam int CTL_OVFL = 6;
    localparam int CTL_EN = 5;
    localparam int CTL_CKP = 4;

    // ****************************************
    // port mode codes and dividers
    // ****************************************
    localparam logic [3:0] MODE_SPI_M4 = 4'h0;
    localparam logic [3:0] MODE_SPI_M16 = 4'h1;
    localparam logic [3:0] MODE_SPI_M64 = 4'h2;
    localparam logic [3:0] MODE_SPI_MTMR = 4'h3;
    localparam logic [3:0] MODE_SPI_S_SS = 4'h4;
    localparam logic [3:0] MODE_SPI_S = 4'h5;
    localparam logic [3:0] MODE_I2C_S7 = 4'h6;
    localparam logic [3:0] MODE_I2C_S10 = 4'h7;
    localparam logic [3:0] MODE_I2C_FWM = 4'hB;
    localparam logic [3:0] MODE_I2C_S7_SP = 4'hE;
    localparam logic [3:0] MODE_I2C_S10_SP = 4'hF;
    localparam logic [6:0] DIV_4 = 7'h04;
    localparam logic [6:0] DIV_16 = 7'h10;
    localparam logic [6:0] DIV_64 = 7'h40;
    localparam logic [6:0] DIV_NONE = 7'h00;

    // ****************************************
    // interrupt bit positions and bus answers
    // ****************************************
    localparam int IRQ_W = 5;
    localparam int IRQ_BYTE = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG = 1;
    localparam int IRQ_OVFL = 2;
    localparam int IRQ_START = 3;
    localparam int IRQ_STOP = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ****************************************
    // status register layout, top two bits unused
    // ****************************************
    typedef struct packed {
        logic data_not_addr;
        logic stop_seen;
        logic start_seen;
        logic read_dir;
        logic address_update_flag;
        logic buffer_full_flag;
    } ssc_status_t;

    // ****************************************
    // whole state of the block
    // ****************************************
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [7:0] aw_addr;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic write_collision_flag;
        logic receive_overflow_flag;
        logic port_enable_bit;
        logic clock_polarity_bit;
        logic [3:0] port_mode_field;
        logic i2c_sel;
        logic spi_master;
        logic [6:0] spi_divider;
        ssc_status_t sts;
        logic tx_in_flight;
        logic [7:0] serial_data_buffer;
        logic [7:0] slave_address_register;
        logic tx_load;
        logic [7:0] tx_data;
        logic [IRQ_W-1:0] irq_sts;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
    } ssc_state_t;

endpackage : ssc_pkg

//--- design/ssc_unused_none.sv
`timescale 1ns/1ps
// intentionally empty

//--- verif/ssc_eng_model.sv
// shift engine stand-in: drives event pulses and qualifiers into the port
// assumes the bench calls its tasks and that everything runs on i_clk_sys
`timescale 1ns/1ps

module ssc_eng_model (
    // clock
    input wire logic i_clk_sys,
    // engine events
    output logic o_busy,
    output logic [6:0] o_ev,
    output logic [7:0] o_data,
    output logic o_flag
);
    initial
    begin
        o_busy = 1'b0;
        o_ev = 7'h00;
        o_data = 8'h00;
        o_flag = 1'b0;
    end

    // ****
    // one-cycle event, qualifiers garbled after it
    // ****
    task automatic fire(input int k, input logic [7:0] d, input logic f);
        @(posedge i_clk_sys);
        o_ev <= 7'h01 << k;
        o_data <= d;
        o_flag <= f;
        @(posedge i_clk_sys);
        o_ev <= 7'h00;
        o_data <= ~d;
        o_flag <= ~f;
    endtask : fire

    task automatic set_busy(input logic b);
        @(posedge i_clk_sys);
        o_busy <= b;
    endtask : set_busy
endmodule : ssc_eng_model

//--- verif/ssc_chk_asserts.sv
// assertions on the ports of ssc_top, attached by bind
// assumes one clock i_clk_sys and synchronous reset i_rst
`timescale 1ns/1ps

module ssc_chk (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // bus
    input wire logic i_bready,
    input wire logic o_bvalid,
    input wire logic [1:0] o_bresp,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic i_rready,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    // engine configuration
    input wire logic o_pins_to_port,
    input wire logic o_i2c_sel,
    input wire logic o_spi_master,
    input wire logic [6:0] o_spi_divider,
    input wire logic [3:0] o_port_mode,
    input wire logic o_tx_load
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence s_rd_taken;
        i_arvalid && o_arready;
    endsequence

    sequence s_resp_back;
        o_rvalid ##0 $stable(o_rdata);
    endsequence

    a_read_answer: assert property (s_rd_taken |=> o_rvalid)
        else $error("read not answered");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> s_resp_back)
        else $error("read data dropped early");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped early");
    a_mode_i2c: assert property (
        o_pins_to_port |-> o_i2c_sel == (o_port_mode inside {4'h6, 4'h7, 4'hB, 4'hE, 4'hF}))
        else $error("protocol select wrong");
    a_mode_master: assert property (
        o_pins_to_port |-> o_spi_master == (o_port_mode <= 4'h3))
        else $error("master select wrong");
    a_div_code: assert property (o_pins_to_port && o_port_mode <= 4'h2 |->
        o_spi_divider == (o_port_mode == 4'h0 ? ssc_pkg::DIV_4 :
        o_port_mode == 4'h1 ? ssc_pkg::DIV_16 : ssc_pkg::DIV_64))
        else $error("divider wrong");
    a_pins_by_write: assert property ($changed(o_pins_to_port) |-> ##[0:1] $rose(o_bvalid))
        else $error("pin handover without a write");
    a_load_pulse: assert property (o_tx_load |=> !o_tx_load)
        else $error("load pulse too long");
endmodule : ssc_chk

bind ssc_top ssc_chk u_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_bready(i_bready), .o_bvalid(o_bvalid),
    .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_rready(i_rready),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_pins_to_port(o_pins_to_port),
    .o_i2c_sel(o_i2c_sel), .o_spi_master(o_spi_master), .o_spi_divider(o_spi_divider),
    .o_port_mode(o_port_mode), .o_tx_load(o_tx_load)
);

//--- verif/tb_top.sv
// bench for ssc_top: axi4-lite tasks, engine model, self checks
// assumes the package, design, checker and engine model compile first
`timescale 1ns/1ps

module tb_top;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready, c;
    logic [7:0] awaddr, araddr, tx_seen, b0;
    logic [31:0] wdata, rq;
    logic [1:0] resp;
    logic [3:0] m;
    logic [3:0] modes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
    int errors, samples_checked, seed;
    wire logic awready, wready, bvalid, arready, rvalid, pins, i2c, spim, idle, rel, txl, irq;
    wire logic busy, eflag;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [6:0] div, ev;
    wire logic [3:0] pmode;
    wire logic [7:0] saddr, txd, edat;

    ssc_eng_model eng (.i_clk_sys(clk), .o_busy(busy), .o_ev(ev), .o_data(edat), .o_flag(eflag));

    ssc_top dut (
        .i_clk_sys(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
        .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rvalid(rvalid),
        .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready), .i_shift_busy(busy),
        .i_rx_done(ev[0]), .i_rx_data(edat), .i_tx_done(ev[1]), .i_byte_is_data(eflag),
        .i_start_det(ev[2]), .i_stop_det(ev[3]), .i_addr_match(ev[4]), .i_rw_bit(eflag),
        .i_ack_det(ev[5]), .i_ua_req(ev[6]), .o_pins_to_port(pins), .o_i2c_sel(i2c),
        .o_spi_master(spim), .o_spi_divider(div), .o_clk_idle_high(idle),
        .o_i2c_clk_release(rel), .o_port_mode(pmode), .o_slave_addr(saddr),
        .o_tx_load(txl), .o_tx_data(txd), .o_irq(irq)
    );

    // ****
    // checks and closing
    // ****
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic tmo(input int n);
        if (n >= 60)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, n, 0);
            report_and_stop();
        end
    endtask : tmo

    // ****
    // bus tasks
    // ****
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 60);
        resp = bresp;
        bready <= 1'b0;
        tmo(n);
    endtask : wr

    task automatic rck(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 60);
        rq = rdata;
        resp = rresp;
        rready <= 1'b0;
        tmo(n);
        chk(rq & k, e);
    endtask : rck

    // expected {i2c, master, idle, release, mode, divider}
    function automatic logic [14:0] exp_cfg(input logic [3:0] md, input logic p);
        logic [6:0] dv;
        dv = md == 4'h0 ? ssc_pkg::DIV_4 : md == 4'h1 ? ssc_pkg::DIV_16 :
            md == 4'h2 ? ssc_pkg::DIV_64 : ssc_pkg::DIV_NONE;
        return {md inside {4'h6, 4'h7, 4'hB, 4'hE, 4'hF}, md <= 4'h3, p, p, md, dv};
    endfunction : exp_cfg

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
        if (txl === 1'b1) tx_seen <= txd;

    initial
    begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = 48'h0;
        errors = 0;
        samples_checked = 0;
        seed = 61463;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rck(ssc_pkg::OFS_STATUS, 32'hFFFFFFFF, 32'h0);
        wr(ssc_pkg::OFS_STATUS, 32'hFF);
        chk(resp, ssc_pkg::RESP_OKAY);
        rck(ssc_pkg::OFS_STATUS, 32'hFFFFFFFF, 32'h0);
        rck(8'h40, 32'hFFFFFFFF, 32'h0);
        chk(resp, ssc_pkg::RESP_SLVERR);
        wr(8'h40, 32'h0);
        chk(resp, ssc_pkg::RESP_SLVERR);
        $display("test registers done");
        foreach (modes[i])
        begin
            m = modes[i];
            c = 1'($random(seed));
            wr(ssc_pkg::OFS_CONTROL, 32'({3'b001, c, m}));
            rck(ssc_pkg::OFS_CONTROL, 32'hFF, 32'({3'b001, c, m}));
            chk({pins, i2c, spim, idle, rel, pmode, div}, {1'b1, exp_cfg(m, c)});
        end
        $display("test modes done");
        b0 = 8'($random(seed)) | 8'h01;
        wr(ssc_pkg::OFS_IRQ_MASK, 32'h1 << ssc_pkg::IRQ_OVFL);
        wr(ssc_pkg::OFS_CONTROL, 32'h3E);
        eng.fire(2, 8'h00, 1'b0);
        rck(ssc_pkg::OFS_STATUS, 32'hFF, 32'h08);
        eng.fire(4, 8'h00, 1'b1);
        rck(ssc_pkg::OFS_STATUS, 32'hFF, 32'h0C);
        eng.fire(0, b0, 1'b0);
        rck(ssc_pkg::OFS_STATUS, 32'hFF, 32'h0D);
        chk(irq, 1'b0);
        eng.fire(5, 8'h00, 1'b0);
        rck(ssc_pkg::OFS_STATUS, 32'hFF, 32'h09);
        eng.fire(0, ~b0, 1'b1);
        rck(ssc_pkg::OFS_CONTROL, 32'hFF, 32'h7E);
        chk(irq, 1'b1);
        wr(ssc_pkg::OFS_IRQ_STS, 32'h1F);
        rck(ssc_pkg::OFS_DATA_BUF, 32'hFF, 32'(b0));
        chk(irq, 1'b0);
        eng.fire(0, b0, 1'b1);
        rck(ssc_pkg::OFS_STATUS, 32'h21, 32'h21);
        rck(ssc_pkg::OFS_DATA_BUF, 32'hFF, 32'(b0));
        eng.fire(3, 8'h00, 1'b0);
        rck(ssc_pkg::OFS_STATUS, 32'h1F, 32'h10);
        wr(ssc_pkg::OFS_CONTROL, 32'h1E);
        rck(ssc_pkg::OFS_STATUS, 32'h18, 32'h0);
        $display("test i2c flags done");
        wr(ssc_pkg::OFS_CONTROL, 32'h3F);
        eng.fire(6, 8'h00, 1'b0);
        rck(ssc_pkg::OFS_STATUS, 32'h02, 32'h02);
        wr(ssc_pkg::OFS_SLV_ADDR, 32'h5A);
        chk(saddr, 8'h5A);
        rck(ssc_pkg::OFS_STATUS, 32'h02, 32'h0);
        wr(ssc_pkg::OFS_DATA_BUF, 32'(b0));
        rck(ssc_pkg::OFS_STATUS, 32'h01, 32'h01);
        chk(tx_seen, b0);
        eng.fire(1, 8'h00, 1'b0);
        rck(ssc_pkg::OFS_STATUS, 32'h01, 32'h0);
        $display("test transmit done");
        wr(ssc_pkg::OFS_CONTROL, 32'h20);
        eng.set_busy(1'b1);
        wr(ssc_pkg::OFS_DATA_BUF, 32'h3C);
        eng.set_busy(1'b0);
        repeat (20) @(posedge clk);
        rck(ssc_pkg::OFS_CONTROL, 32'h80, 32'h80);
        chk(tx_seen, b0);
        wr(ssc_pkg::OFS_CONTROL, 32'h20);
        rck(ssc_pkg::OFS_CONTROL, 32'h80, 32'h0);
        eng.fire(0, b0, 1'b0);
        eng.fire(0, b0, 1'b0);
        rck(ssc_pkg::OFS_CONTROL, 32'h40, 32'h0);
        rck(ssc_pkg::OFS_STATUS, 32'h01, 32'h01);
        $display("test spi done");
        report_and_stop();
    end
endmodule : tb_top
